// ---- rtl/lvdic_pkg.sv ----
// Package holding the register map, field positions and constants of the detector and interrupt block.
package lvdic_pkg;
  localparam logic [7:0] LVDIC_OFF_LVD_CTRL  = 8'h00;
  localparam logic [7:0] LVDIC_OFF_EDGE_SEL  = 8'h04;
  localparam logic [7:0] LVDIC_OFF_PRI_CTL0  = 8'h08;
  localparam logic [7:0] LVDIC_OFF_PRI_CTL1  = 8'h0c;
  localparam logic [7:0] LVDIC_OFF_PRI_CTL2  = 8'h10;
  localparam logic [7:0] LVDIC_OFF_GRP0      = 8'h14;
  localparam logic [7:0] LVDIC_OFF_GRP1      = 8'h18;
  localparam logic [7:0] LVDIC_OFF_GRP2      = 8'h1c;
  localparam logic [7:0] LVDIC_OFF_SYS_STAT  = 8'h20;
  localparam logic [7:0] LVDIC_RST_BYTE      = 8'h00;
  // Detector control field positions.
  localparam int LVDIC_BIT_LOW_FLAG  = 5;
  localparam int LVDIC_BIT_DET_EN    = 4;
  localparam int LVDIC_BIT_REF_EN    = 3;
  // Register write masks; unimplemented bits stay zero.
  localparam logic [7:0] LVDIC_MASK_LVD_CTRL = 8'h1f;
  localparam logic [7:0] LVDIC_MASK_EDGE_SEL = 8'h0f;
  localparam logic [7:0] LVDIC_MASK_PRI_CTL0 = 8'h7f;
  localparam logic [7:0] LVDIC_MASK_PRI_CTL2 = 8'h33;
  localparam logic [7:0] LVDIC_MASK_GRP_HALF = 8'h33;
  localparam logic [7:0] LVDIC_MASK_GRP_FULL = 8'hff;
  // Qualifying delay: time the low flag must stay high before the request.
  localparam int LVDIC_CLK_MHZ       = 25;
  localparam int LVDIC_QUAL_US       = 1;
  localparam int LVDIC_QUAL_CYCLES   = LVDIC_QUAL_US * LVDIC_CLK_MHZ;
  localparam logic [1:0] LVDIC_EDGE_OFF  = 2'h0;
  localparam logic [1:0] LVDIC_EDGE_RISE = 2'h1;
  localparam logic [1:0] LVDIC_EDGE_FALL = 2'h2;
  localparam logic [1:0] LVDIC_EDGE_BOTH = 2'h3;
  typedef enum logic [2:0] {
    LVDIC_Q_IDLE = 3'b001,
    LVDIC_Q_WAIT = 3'b010,
    LVDIC_Q_DONE = 3'b100
  } lvdic_qual_t;
endpackage

// ---- rtl/lvdic_edge_det.sv ----
// Synchroniser and selectable edge detector for one external request pin.
`timescale 1ns/1ps
module lvdic_edge_det
  import lvdic_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  output logic            hit
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } lvdic_edge_st_t;
  lvdic_edge_st_t st_reg, st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Edge decode reads only the second and third stages of the chain.
  always_comb begin
    case (edge_sel)
      LVDIC_EDGE_RISE: hit = st_reg.s2 & ~st_reg.s3; // see [RL16]
      LVDIC_EDGE_FALL: hit = ~st_reg.s2 & st_reg.s3; // see [RL16]
      LVDIC_EDGE_BOTH: hit = st_reg.s2 ^ st_reg.s3; // see [RL16]
      default:         hit = 1'b0;
    endcase
  end
endmodule // lvdic_edge_det

// ---- rtl/lvdic_top.sv ----
// Low-voltage detector control with interrupt enable and request flag registers.
// Operation
// [RL1] Detector control bits seven, six read zero.
// [RL2] Bit five reads supply-below-threshold comparator result.
// [RL3] Bit four enables detector; resets to zero.
// [RL4] Reference on if bit three, detector or reset.
// [RL5] Three-bit threshold selects one of eight levels.
// [RL6] Sleep holds detector disabled regardless of enable.
// [RL7] Software waits stabilisation before trusting flag.
// [RL8] Request set only after flag stays high.
// [RL9] Qualified low condition sets detector request flag.
// [RL10] New detector request wakes core from idle.
// [RL11] Detector request merged into shared group.
// [RL12] Some sources own vector; others share group.
// [RL13] Hardware sets flags; software writes enables.
// [RL14] Second periodic timer bits only when configured.
// [RL15] Two pins plus internal sources raise requests.
// [RL16] Edge field: off, rising, falling, both.
// [RL17] Taken needs flag, enable, global, group enable.
// [RL18] Group flag set by enabled pending sub-source.
//
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module lvdic_top
  import lvdic_pkg::*;
#(
  parameter int QUAL_CYCLES   = LVDIC_QUAL_CYCLES,
  parameter bit TWO_PER_TIMER = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hsel,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        supply_below_cmp,
  input  wire logic        sleep_mode,
  input  wire logic        idle_mode,
  input  wire logic        low_voltage_reset,
  input  wire logic        ext_pin_0,
  input  wire logic        ext_pin_1,
  input  wire logic        serial_if_event,
  input  wire logic        converter_event,
  input  wire logic [1:0]  timebase_event,
  input  wire logic [1:0]  std_timer_event,
  input  wire logic [3:0]  periodic_timer_event,
  input  wire logic        nvm_event,
  output logic             detector_power,
  output logic             reference_power,
  output logic [2:0]       threshold_select,
  output logic             wake_idle,
  output logic [8:0]       int_pending
);
  localparam logic [7:0] GRP1_MASK = TWO_PER_TIMER ? LVDIC_MASK_GRP_FULL : LVDIC_MASK_GRP_HALF;

  typedef struct packed {
    logic [7:0]  lvd_ctrl;
    logic [7:0]  edge_sel;
    logic [7:0]  pri0;
    logic [7:0]  pri1;
    logic [7:0]  pri2;
    logic [7:0]  grp0;
    logic [7:0]  grp1;
    logic [7:0]  grp2;
    logic        cmp_s1;
    logic        cmp_s2;
    lvdic_qual_t qual;
    logic [15:0] qcnt;
    logic        wr_pend;
    logic [7:0]  addr;
    logic [31:0] rdata;
    logic        det_pwr;
    logic        ref_pwr;
    logic [2:0]  thr;
    logic        wake;
    logic [8:0]  pend;
  } lvdic_st_t;
  lvdic_st_t st_reg, st_next;

  logic [1:0] pin_hit;
  logic       det_on;
  logic       low_flag;
  logic       qual_hit;
  logic       addr_ok;
  logic [7:0] set0, set1, set2, setg0, setg1, setg2;
  logic [7:0] wb;

  lvdic_edge_det u_pin0 (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin      (ext_pin_0),
    .edge_sel (st_reg.edge_sel[1:0]),
    .hit      (pin_hit[0])
  );
  lvdic_edge_det u_pin1 (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin      (ext_pin_1),
    .edge_sel (st_reg.edge_sel[3:2]),
    .hit      (pin_hit[1])
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Hardware set terms, one vector per register.
  always_comb begin
    det_on   = st_reg.lvd_ctrl[LVDIC_BIT_DET_EN] & ~sleep_mode; // see [RL6]
    low_flag = det_on & st_reg.cmp_s2; // see [RL2]
    // The flag must still be high in the last counted cycle as well.
    qual_hit = low_flag && (st_reg.qual == LVDIC_Q_WAIT) &&
               (st_reg.qcnt >= 16'(QUAL_CYCLES - 1));
    set0  = {1'b0, serial_if_event, pin_hit[1], pin_hit[0], 4'h0}; // see [RL15]
    setg0 = {2'b00, std_timer_event[1], std_timer_event[0], 4'h0};
    setg1 = {periodic_timer_event[3:2] & {2{TWO_PER_TIMER}},
             periodic_timer_event[1:0], 4'h0}; // see [RL14]
    setg2 = {2'b00, nvm_event, qual_hit, 4'h0}; // see [RL9] [RL11]
    // Group flag rises when any enabled sub-source is pending.
    set1  = {converter_event,
             |(st_reg.grp1[7:4] & st_reg.grp1[3:0]),
             |(st_reg.grp0[7:4] & st_reg.grp0[3:0]),
             |(st_reg.grp2[7:4] & st_reg.grp2[3:0]), 4'h0}; // see [RL18]
    set2  = {2'b00, timebase_event, 4'h0};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: bus slave, qualifier, flags, outputs.
  always_comb begin
    st_next = st_reg;
    addr_ok = 1'b1;
    wb      = hwdata[7:0];
    st_next.cmp_s1 = supply_below_cmp;
    st_next.cmp_s2 = st_reg.cmp_s1;

    // The qualifier restarts whenever the flag drops, so glitches near the
    // trip level never reach the request flag.
    case (st_reg.qual)
      LVDIC_Q_IDLE: begin
        st_next.qcnt = '0;
        if (low_flag) begin
          st_next.qual = LVDIC_Q_WAIT;
        end
      end
      LVDIC_Q_WAIT: begin
        if (!low_flag) begin
          st_next.qual = LVDIC_Q_IDLE;
        end else if (qual_hit) begin
          st_next.qual = LVDIC_Q_DONE; // see [RL8]
        end else begin
          st_next.qcnt = st_reg.qcnt + 16'h0001;
        end
      end
      LVDIC_Q_DONE: begin
        if (!low_flag) begin
          st_next.qual = LVDIC_Q_IDLE;
        end
      end
      default: st_next.qual = LVDIC_Q_IDLE;
    endcase

    // Data phase of a write, then hardware sets win over software clears.
    if (st_reg.wr_pend) begin
      case (st_reg.addr)
        LVDIC_OFF_LVD_CTRL: st_next.lvd_ctrl = wb & LVDIC_MASK_LVD_CTRL; // see [RL1] [RL3] [RL5]
        LVDIC_OFF_EDGE_SEL: st_next.edge_sel = wb & LVDIC_MASK_EDGE_SEL;
        LVDIC_OFF_PRI_CTL0: st_next.pri0 = wb & LVDIC_MASK_PRI_CTL0; // see [RL13]
        LVDIC_OFF_PRI_CTL1: st_next.pri1 = wb;
        LVDIC_OFF_PRI_CTL2: st_next.pri2 = wb & LVDIC_MASK_PRI_CTL2;
        LVDIC_OFF_GRP0:     st_next.grp0 = wb & LVDIC_MASK_GRP_HALF;
        LVDIC_OFF_GRP1:     st_next.grp1 = wb & GRP1_MASK; // see [RL14]
        LVDIC_OFF_GRP2:     st_next.grp2 = wb & LVDIC_MASK_GRP_HALF;
        default:            addr_ok = 1'b0;
      endcase
    end
    st_next.pri0 = st_next.pri0 | set0; // see [RL13]
    st_next.pri1 = st_next.pri1 | set1;
    st_next.pri2 = st_next.pri2 | set2;
    st_next.grp0 = st_next.grp0 | setg0;
    st_next.grp1 = st_next.grp1 | (setg1 & GRP1_MASK);
    st_next.grp2 = st_next.grp2 | setg2;

    // Address phase capture; a single cycle answer keeps hreadyout high.
    st_next.wr_pend = hsel & hready & htrans[1] & hwrite;
    if (hsel & hready & htrans[1]) begin
      st_next.addr = {haddr[7:2], 2'b00};
    end
    if (hsel & hready & htrans[1] & ~hwrite) begin
      case ({haddr[7:2], 2'b00})
        LVDIC_OFF_LVD_CTRL: st_next.rdata = {24'h0, 2'b00, low_flag,
                                             st_reg.lvd_ctrl[4:0]}; // see [RL1] [RL2]
        LVDIC_OFF_EDGE_SEL: st_next.rdata = {24'h0, st_reg.edge_sel};
        LVDIC_OFF_PRI_CTL0: st_next.rdata = {24'h0, st_reg.pri0};
        LVDIC_OFF_PRI_CTL1: st_next.rdata = {24'h0, st_reg.pri1};
        LVDIC_OFF_PRI_CTL2: st_next.rdata = {24'h0, st_reg.pri2};
        LVDIC_OFF_GRP0:     st_next.rdata = {24'h0, st_reg.grp0};
        LVDIC_OFF_GRP1:     st_next.rdata = {24'h0, st_reg.grp1};
        LVDIC_OFF_GRP2:     st_next.rdata = {24'h0, st_reg.grp2};
        LVDIC_OFF_SYS_STAT: st_next.rdata = {29'h0, st_reg.qual};
        default:            st_next.rdata = 32'h0;
      endcase
    end

    st_next.det_pwr = det_on;
    st_next.ref_pwr = st_reg.lvd_ctrl[LVDIC_BIT_REF_EN] | det_on | low_voltage_reset; // see [RL4]
    st_next.thr     = st_reg.lvd_ctrl[2:0]; // see [RL5]
    // Only a freshly set detector request wakes the core; a flag already high
    // before idle suppresses the wake.
    st_next.wake = idle_mode & setg2[4] & ~st_reg.grp2[4]; // see [RL10]
    // Vector order: pin0, pin1, serial, group0, group1, group2, converter,
    // timebase0, timebase1. Groups share the common vector path.
    st_next.pend[0] = st_reg.pri0[0] & st_reg.pri0[4] & st_reg.pri0[1]; // see [RL17] [RL12]
    st_next.pend[1] = st_reg.pri0[0] & st_reg.pri0[5] & st_reg.pri0[2];
    st_next.pend[2] = st_reg.pri0[0] & st_reg.pri0[6] & st_reg.pri0[3];
    st_next.pend[3] = st_reg.pri0[0] & st_reg.pri1[5] & st_reg.pri1[1]; // see [RL17]
    st_next.pend[4] = st_reg.pri0[0] & st_reg.pri1[6] & st_reg.pri1[2];
    st_next.pend[5] = st_reg.pri0[0] & st_reg.pri1[4] & st_reg.pri1[0]; // see [RL11]
    st_next.pend[6] = st_reg.pri0[0] & st_reg.pri1[7] & st_reg.pri1[3];
    st_next.pend[7] = st_reg.pri0[0] & st_reg.pri2[4] & st_reg.pri2[0];
    st_next.pend[8] = st_reg.pri0[0] & st_reg.pri2[5] & st_reg.pri2[1];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg      <= '0;
      st_reg.qual <= LVDIC_Q_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    hrdata          = st_reg.rdata;
    hreadyout       = 1'b1;
    hresp           = 1'b0;
    detector_power  = st_reg.det_pwr;
    reference_power = st_reg.ref_pwr;
    threshold_select = st_reg.thr;
    wake_idle       = st_reg.wake;
    int_pending     = st_reg.pend;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic unused_ok;
  assign unused_ok = addr_ok | (|hsize);

  property qual_wait_p;
    @(posedge ref_clk) disable iff (rst)
      $rose(st_reg.grp2[4]) && !$past(st_reg.wr_pend) |-> $past(low_flag, 2);
  endproperty
  qual_delay_a: assert property (qual_wait_p) // see [RL8]
    else $error("detector request set without qualified low flag");
  low_flag_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL2]
    sleep_mode |-> !low_flag)
    else $error("low flag visible during sleep");
  det_sleep_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL6]
    sleep_mode |=> !detector_power)
    else $error("detector powered in sleep");
  ref_power_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL4]
    detector_power |-> reference_power)
    else $error("reference off while detector on");
  rd_upper_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL1]
    $past(hsel & htrans[1] & ~hwrite) && $past(haddr[7:0]) == LVDIC_OFF_LVD_CTRL
    |-> hrdata[7:6] == 2'b00)
    else $error("unimplemented detector bits read nonzero");
  pend_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL17]
    int_pending[5] |-> $past(st_reg.pri0[0] & st_reg.pri1[0] & st_reg.pri1[4]))
    else $error("group request taken without all enables");
  grp_set_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL18]
    |(st_reg.grp2[7:4] & st_reg.grp2[3:0]) |=> st_reg.pri1[4])
    else $error("group flag not set by pending sub-source");
  wake_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL10]
    wake_idle |-> $past(idle_mode) && !$past(st_reg.grp2[4]))
    else $error("wake without fresh detector request");
  thr_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL5]
    threshold_select == $past(st_reg.lvd_ctrl[2:0]))
    else $error("threshold output mismatch");
  grp1_hi_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL14]
    !TWO_PER_TIMER |-> st_reg.grp1[7:6] == 2'b00 && st_reg.grp1[3:2] == 2'b00)
    else $error("second timer bits set in small configuration");
  set_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL13]
    pin_hit[0] |=> st_reg.pri0[4])
    else $error("pin request lost");
  // Every source pulse must leave its flag set one cycle later, even when
  // software writes the same register in that cycle.
  pin1_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL15]
    pin_hit[1] |=> st_reg.pri0[5])
    else $error("second pin request lost");
  serial_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL15]
    serial_if_event |=> st_reg.pri0[6])
    else $error("serial request lost");
  conv_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL13]
    converter_event |=> st_reg.pri1[7])
    else $error("converter request lost");
  tbase_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL13]
    timebase_event[0] |=> st_reg.pri2[4])
    else $error("time base request lost");
  nvm_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL15]
    nvm_event |=> st_reg.grp2[5])
    else $error("memory request lost");

  // Qualifier and detector request.
  qual_state_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL8]
    $rose(st_reg.grp2[4]) && !$past(st_reg.wr_pend) |-> $past(st_reg.qual == LVDIC_Q_WAIT))
    else $error("detector request set outside the qualifying wait");
  qual_restart_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL8]
    !low_flag |=> st_reg.qual == LVDIC_Q_IDLE)
    else $error("qualifier kept running after the flag dropped");
  sleep_req_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL6]
    sleep_mode |-> !qual_hit)
    else $error("detector request qualified during sleep");
  flag_cmp_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL2]
    !st_reg.cmp_s2 |-> !low_flag)
    else $error("low flag without comparator result");
  wake_new_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL10]
    idle_mode && qual_hit && !st_reg.grp2[4] |=> wake_idle)
    else $error("fresh detector request did not wake");

  // Control register, power outputs, taken requests and group flags.
  ctrl_upper_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL1]
    st_reg.lvd_ctrl[7:5] == 3'b000)
    else $error("unimplemented detector bits stored");
  det_enable_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL3]
    detector_power |-> $past(st_reg.lvd_ctrl[LVDIC_BIT_DET_EN]))
    else $error("detector powered while disabled");
  ref_enable_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL4]
    $past(st_reg.lvd_ctrl[LVDIC_BIT_REF_EN] | low_voltage_reset) |-> reference_power)
    else $error("reference off while requested");
  pend_global_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL17]
    (|int_pending) |-> $past(st_reg.pri0[0]))
    else $error("request taken with global enable off");
  grp0_set_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL18]
    |(st_reg.grp0[7:4] & st_reg.grp0[3:0]) |=> st_reg.pri1[5])
    else $error("group 0 flag not set by pending sub-source");
  grp1_set_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL18]
    |(st_reg.grp1[7:4] & st_reg.grp1[3:0]) |=> st_reg.pri1[6])
    else $error("group 1 flag not set by pending sub-source");
  cov_grp0_c: cover property (@(posedge ref_clk) disable iff (rst) int_pending[3]);
  cov_qual_c: cover property (@(posedge ref_clk) disable iff (rst) $rose(st_reg.grp2[4]));
  cov_wake_c: cover property (@(posedge ref_clk) disable iff (rst) wake_idle);
  cov_pin_c: cover property (@(posedge ref_clk) disable iff (rst) int_pending[0]);
  cov_grp_c: cover property (@(posedge ref_clk) disable iff (rst) int_pending[5]);
endmodule // lvdic_top

// ---- testbench/lvdic_top_tb.sv ----
// Self-checking bench for the detector control and interrupt flag block.
`timescale 1ns/1ps
module lvdic_top_tb;
  import lvdic_pkg::*;
  localparam int QUAL  = 8;
  localparam int LIMIT = 20000;
  logic        ref_clk, rst, hwrite, hsel, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, timebase_event, std_timer_event;
  logic [2:0]  hsize, threshold_select;
  logic        supply_below_cmp, sleep_mode, idle_mode, low_voltage_reset;
  logic        ext_pin_0, ext_pin_1, serial_if_event, converter_event, nvm_event;
  logic [3:0]  periodic_timer_event;
  logic        detector_power, reference_power, wake_idle;
  logic [8:0]  int_pending;
  int          err_count, checks, cycles, wake_count;
  logic [7:0]  offs [9] = '{LVDIC_OFF_LVD_CTRL, LVDIC_OFF_EDGE_SEL, LVDIC_OFF_PRI_CTL0,
    LVDIC_OFF_PRI_CTL1, LVDIC_OFF_PRI_CTL2, LVDIC_OFF_GRP0, LVDIC_OFF_GRP1, LVDIC_OFF_GRP2, 8'h24};
  logic [7:0]  masks [9] = '{8'h1f, 8'h0f, 8'h7f, 8'hff, 8'h33, 8'h33, 8'hff, 8'h33, 8'h00};

  assign hready = hreadyout;
  lvdic_top #(.QUAL_CYCLES(QUAL), .TWO_PER_TIMER(1'b1)) i_lvdic_top (
    .ref_clk(ref_clk), .rst(rst), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .supply_below_cmp(supply_below_cmp),
    .sleep_mode(sleep_mode), .idle_mode(idle_mode), .low_voltage_reset(low_voltage_reset),
    .ext_pin_0(ext_pin_0), .ext_pin_1(ext_pin_1), .serial_if_event(serial_if_event),
    .converter_event(converter_event), .timebase_event(timebase_event),
    .std_timer_event(std_timer_event), .periodic_timer_event(periodic_timer_event),
    .nvm_event(nvm_event), .detector_power(detector_power),
    .reference_power(reference_power), .threshold_select(threshold_select),
    .wake_idle(wake_idle), .int_pending(int_pending));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // A hung wait ends the run here instead of stalling it.
  always @(posedge ref_clk) begin
    cycles++;
    if (wake_idle === 1'b1) wake_count++;
    if (cycles == LIMIT) begin
      err_count++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic ahb_xfer(logic [7:0] a, logic wr, logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [31:0] q;
    ahb_xfer(a, 1'b1, {24'h0, d}, q);
  endtask

  task automatic rd_chk(string name, logic [7:0] a, logic [7:0] exp);
    logic [31:0] q;
    ahb_xfer(a, 1'b0, 32'h0, q);
    check(name, {24'h0, exp}, q);
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_masks();
    foreach (offs[i]) rd_chk("reset value", offs[i], 8'h00);
    foreach (offs[i]) begin
      wr(offs[i], 8'hff);
      rd_chk("write mask", offs[i], masks[i]);
    end
    // Group flags re-raise the shared flags, so a second pass is needed to clear.
    repeat (2) foreach (offs[i]) wr(offs[i], 8'h00);
    rd_chk("cleared ctrl1", LVDIC_OFF_PRI_CTL1, 8'h00);
  endtask

  task automatic t_edges();
    for (int f = 0; f < 4; f++) begin
      wr(LVDIC_OFF_EDGE_SEL, {4'h0, f[1:0], f[1:0]});
      wr(LVDIC_OFF_PRI_CTL0, 8'h00);
      ext_pin_0 <= 1'b1;
      ext_pin_1 <= 1'b1;
      tick(6);
      rd_chk("rise flags", LVDIC_OFF_PRI_CTL0, {2'b00, {2{f[0]}}, 4'h0});
      wr(LVDIC_OFF_PRI_CTL0, 8'h00);
      ext_pin_0 <= 1'b0;
      ext_pin_1 <= 1'b0;
      tick(6);
      rd_chk("fall flags", LVDIC_OFF_PRI_CTL0, {2'b00, {2{f[1]}}, 4'h0});
    end
    wr(LVDIC_OFF_PRI_CTL0, 8'h00);
  endtask

  task automatic t_sources();
    @(posedge ref_clk);
    {serial_if_event, converter_event, nvm_event} <= 3'b111;
    {timebase_event, std_timer_event, periodic_timer_event} <= 8'hff;
    @(posedge ref_clk);
    {serial_if_event, converter_event, nvm_event} <= 3'b000;
    {timebase_event, std_timer_event, periodic_timer_event} <= 8'h00;
    tick(3);
    rd_chk("serial flag", LVDIC_OFF_PRI_CTL0, 8'h40);
    rd_chk("conv flag", LVDIC_OFF_PRI_CTL1, 8'h80);
    rd_chk("timebase flags", LVDIC_OFF_PRI_CTL2, 8'h30);
    rd_chk("group0 flags", LVDIC_OFF_GRP0, 8'h30);
    rd_chk("group1 flags", LVDIC_OFF_GRP1, 8'hf0);
    rd_chk("group2 flags", LVDIC_OFF_GRP2, 8'h20);
    check("no pending", 32'h0, {23'h0, int_pending});
    wr(LVDIC_OFF_GRP0, 8'h33);
    wr(LVDIC_OFF_PRI_CTL0, 8'h01);
    wr(LVDIC_OFF_PRI_CTL1, 8'h02);
    tick(3);
    rd_chk("group0 raised", LVDIC_OFF_PRI_CTL1, 8'h22);
    check("group0 pending", 32'h8, {23'h0, int_pending});
    repeat (2) foreach (offs[i]) wr(offs[i], 8'h00);
  endtask

  task automatic t_detector();
    low_voltage_reset <= 1'b1;
    tick(3);
    check("ref by reset", 32'h1, {31'h0, reference_power});
    low_voltage_reset <= 1'b0;
    wr(LVDIC_OFF_LVD_CTRL, 8'h08);
    tick(3);
    check("ref by bit", 32'h1, {31'h0, reference_power});
    check("det off", 32'h0, {31'h0, detector_power});
    wr(LVDIC_OFF_LVD_CTRL, 8'h15);
    wr(LVDIC_OFF_GRP2, 8'h01);
    wr(LVDIC_OFF_PRI_CTL1, 8'h01);
    wr(LVDIC_OFF_PRI_CTL0, 8'h01);
    // Let the enabled detector settle before its flag is trusted.
    tick(2);
    check("det power", 32'h1, {31'h0, detector_power});
    check("ref by det", 32'h1, {31'h0, reference_power});
    check("threshold", 32'h5, {29'h0, threshold_select});
    idle_mode        <= 1'b1;
    supply_below_cmp <= 1'b1;
    rd_chk("req early", LVDIC_OFF_GRP2, 8'h01);
    rd_chk("low flag", LVDIC_OFF_LVD_CTRL, 8'h35);
    tick(QUAL + 6);
    rd_chk("req set", LVDIC_OFF_GRP2, 8'h11);
    rd_chk("group2 flag", LVDIC_OFF_PRI_CTL1, 8'h11);
    check("group2 pending", 32'h20, {23'h0, int_pending});
    check("wake pulses", 32'h1, wake_count);
    sleep_mode <= 1'b1;
    tick(4);
    check("sleep power", 32'h0, {31'h0, detector_power});
    check("sleep ref", 32'h0, {31'h0, reference_power});
    rd_chk("sleep flag", LVDIC_OFF_LVD_CTRL, 8'h15);
    // A flag still high from the earlier request keeps the next request from waking.
    wr(LVDIC_OFF_GRP2, 8'h11);
    sleep_mode <= 1'b0;
    tick(QUAL + 6);
    rd_chk("qual done", LVDIC_OFF_SYS_STAT, 8'h04);
    check("wake kept", 32'h1, wake_count);
    {sleep_mode, idle_mode, supply_below_cmp} <= 3'b000;
    repeat (2) foreach (offs[i]) wr(offs[i], 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    {err_count, checks, cycles, wake_count} = '0;
    rst = 1'b1;
    {haddr, hwdata} = '0;
    {htrans, hwrite} = '0;
    hsize = 3'h2;
    hsel  = 1'b1;
    {supply_below_cmp, sleep_mode, idle_mode, low_voltage_reset} = '0;
    {ext_pin_0, ext_pin_1, serial_if_event, converter_event, nvm_event} = '0;
    {timebase_event, std_timer_event, periodic_timer_event} = '0;
    tick(20);
    rst <= 1'b0;
    t_reset_and_masks();
    t_edges();
    t_sources();
    t_detector();
    results();
  end
endmodule // lvdic_top_tb
